// ---- pkg/flash_status_map.svh ----
`ifndef FLASH_STATUS_MAP_SVH
`define FLASH_STATUS_MAP_SVH

// Bit positions inside a status word.
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define TIMEOUT_BIT 5
`define SECTOR_TOGGLE_BIT 2
`define ABORT_BIT 1

// Command codes written on the data bus.
`define CMD_PROGRAM 16'h00A0
`define CMD_BUF_LOAD 16'h0025
`define CMD_BUF_CONFIRM 16'h0029
`define CMD_ERASE_SECTOR 16'h0030
`define CMD_ERASE_CHIP 16'h0010
`define CMD_SUSPEND 16'h00B0
`define CMD_RESUME 16'h0030
`define CMD_RESET 16'h00F0
`define CMD_ABORT_RESET 16'h00F0

// Timing counts.
`define CLOCK_MHZ 20
`define OP_TIME_US 200
`define OP_CYCLES (`OP_TIME_US * `CLOCK_MHZ)
`define LIMIT_TIME_US 1000
`define LIMIT_CYCLES (`LIMIT_TIME_US * `CLOCK_MHZ)
`endif

// ---- pkg/flash_status_pkg.sv ----
package flash_status_pkg;
   typedef enum logic [5:0] {
      st_read = 6'b00_0001,
      st_program = 6'b00_0010,
      st_erase = 6'b00_0100,
      st_erase_susp = 6'b00_1000,
      st_prog_susp = 6'b01_0000,
      st_fail = 6'b10_0000
   } op_state_type;
   typedef enum logic [1:0] {
      op_word = 2'b00,
      op_buffer = 2'b01,
      op_sector = 2'b10,
      op_chip = 2'b11
   } op_kind_type;
endpackage

// ---- hdl/pin_sync.sv ----
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic nrst,
   // Asynchronous pins in, synchronised copy out.
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out
);
   logic [WIDTH-1:0] meta_q;

   // Two flip-flops; only the second stage is visible to logic.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         meta_q <= '0;
         pin_out <= '0;
      end else begin
         meta_q <= pin_in;
         pin_out <= meta_q;
      end
   end
endmodule

// ---- hdl/bank_decode.sv ----
module bank_decode #(
   parameter int ADDR_W = 22,
   parameter bit TOP_BOOT = 1'b1
) (
   // Address to decode.
   input wire logic [ADDR_W-1:0] addr,
   // Bank and sector identity.
   output logic [1:0] bank,
   output logic [ADDR_W-1:0] sector_base
);
   // Four banks on the top two address bits; large sectors are 64 kword,
   // small boot sectors 8 kword in the boot bank.
   always_comb begin
      bank = addr[ADDR_W-1 -: 2];
      sector_base = addr & ~((ADDR_W)'(17'h1_FFFF) >> 1);
      if ((TOP_BOOT && bank == 2'b11 && addr[ADDR_W-3:16] == '1) ||
          (!TOP_BOOT && bank == 2'b00 && addr[ADDR_W-3:16] == '0)) begin
         sector_base = addr & ~(ADDR_W)'(16'h1FFF);
      end
   end
endmodule

// ---- hdl/flash_write_status_and_command_port.sv ----
`include "flash_status_map.svh"
module flash_write_status_and_command_port #(
   parameter int ADDR_W = 22,
   parameter bit TOP_BOOT = 1'b1,
   parameter int OP_CYCLES = `OP_CYCLES,
   parameter int LIMIT_CYCLES = `LIMIT_CYCLES
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic nrst,
   // Host strobes, active low except burst_clk, asynchronous to clock.
   input wire logic chip_select_n,
   input wire logic write_n,
   input wire logic output_n,
   input wire logic address_valid_n,
   input wire logic burst_clk,
   input wire logic [ADDR_W-1:0] addr,
   // Data bus as three signals.
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_oe,
   // Configuration bits.
   input wire logic sync_mode,
   input wire logic ready_rising,
   input wire logic ready_early,
   input wire logic [2:0] wait_state_field,
   // Array data for the addressed word, and fault injection from the core.
   input wire logic [15:0] array_data,
   input wire logic force_abort,
   input wire logic force_stall,
   // Ready pin.
   output logic ready,
   output logic ready_oe,
   // Status for observation.
   output logic busy,
   output logic write_strobe,
   output logic [ADDR_W-1:0] write_addr,
   output logic [15:0] write_data
);
   // ------------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------------
   logic [4:0] strobe_s;
   logic [ADDR_W+15:0] bus_s;
   logic [ADDR_W-1:0] addr_s;
   logic [15:0] din_s;
   logic cs_n, we_n, oe_n, av_n, bclk;

   pin_sync #(.WIDTH(5)) strobe_sync (
      .clock(clock),
      .nrst(nrst),
      .pin_in({~chip_select_n, ~write_n, ~output_n, ~address_valid_n, burst_clk}),
      .pin_out(strobe_s)
   );
   pin_sync #(.WIDTH(ADDR_W + 16)) bus_sync (
      .clock(clock),
      .nrst(nrst),
      .pin_in({addr, data_in}),
      .pin_out(bus_s)
   );
   assign {cs_n, we_n, oe_n, av_n, bclk} = {~strobe_s[4:1], strobe_s[0]}; // Idle from reset.
   assign {addr_s, din_s} = bus_s;

   // Previous strobe values for edge detection.
   logic cs_n_q, we_n_q, oe_n_q, bclk_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cs_n_q <= 1'b1;
         we_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         bclk_q <= 1'b0;
      end else begin
         cs_n_q <= cs_n;
         we_n_q <= we_n;
         oe_n_q <= oe_n;
         bclk_q <= bclk;
      end
   end

   logic wr_n, wr_n_q, wr_fall, wr_rise, bclk_rise, rd_fall;
   // Combined write active when both strobes low with output_n high: the later fall starts it
   // and the first rise ends it.
   assign wr_n = cs_n | we_n | ~oe_n;
   assign wr_n_q = cs_n_q | we_n_q | ~oe_n_q;
   assign wr_fall = wr_n_q & ~wr_n;
   assign wr_rise = ~wr_n_q & wr_n;
   assign bclk_rise = bclk & ~bclk_q & sync_mode;
   assign rd_fall = ~cs_n & ~oe_n & (oe_n_q | cs_n_q);

   // ------------------------------------------------------------------
   // Write capture
   // ------------------------------------------------------------------
   logic [ADDR_W-1:0] lat_addr_q, wr_addr_q;
   logic wr_pulse_q, clk_lat_q;
   logic [15:0] wr_data_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         lat_addr_q <= '0;
         clk_lat_q <= 1'b0;
         wr_pulse_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= 16'h0000;
      end else begin
         wr_pulse_q <= wr_rise;
         if (bclk_rise && !av_n && !cs_n && oe_n) begin
            lat_addr_q <= addr_s;
            clk_lat_q <= 1'b1; // The write strobe must not overwrite it.
         end else if (wr_fall && av_n && !clk_lat_q) begin
            lat_addr_q <= addr_s;
         end else if (cs_n || wr_rise) begin
            clk_lat_q <= 1'b0;
         end
         if (wr_rise) begin
            wr_addr_q <= (sync_mode ? lat_addr_q : lat_addr_q);
            wr_data_q <= din_s;
         end
      end
   end
   assign write_strobe = wr_pulse_q;
   assign write_addr = wr_addr_q;
   assign write_data = wr_data_q;

   // ------------------------------------------------------------------
   // Bank decode for command and read addresses
   // ------------------------------------------------------------------
   logic [1:0] wr_bank, rd_bank;
   logic [ADDR_W-1:0] wr_sector, rd_sector;
   bank_decode #(.ADDR_W(ADDR_W), .TOP_BOOT(TOP_BOOT)) wr_dec (
      .addr(wr_addr_q),
      .bank(wr_bank),
      .sector_base(wr_sector)
   );
   bank_decode #(.ADDR_W(ADDR_W), .TOP_BOOT(TOP_BOOT)) rd_dec (
      .addr(addr_s),
      .bank(rd_bank),
      .sector_base(rd_sector)
   );

   // ------------------------------------------------------------------
   // Embedded operation state machine
   // ------------------------------------------------------------------
   flash_status_pkg::op_state_type state_q;
   flash_status_pkg::op_kind_type kind_q;
   logic [1:0] op_bank_q;
   logic [ADDR_W-1:0] op_sector_q;
   logic last_bit7_q, abort_q, timeout_q, buf_armed_q;
   logic [31:0] op_cnt_q;
   logic [15:0] cmd;
   assign cmd = wr_data_q;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_q <= flash_status_pkg::st_read;
         kind_q <= flash_status_pkg::op_word;
         op_bank_q <= 2'b00;
         op_sector_q <= '0;
         last_bit7_q <= 1'b0;
         abort_q <= 1'b0;
         timeout_q <= 1'b0;
         buf_armed_q <= 1'b0;
         op_cnt_q <= 32'h0000_0000;
      end else begin
         if (state_q == flash_status_pkg::st_program ||
             state_q == flash_status_pkg::st_erase) begin
            op_cnt_q <= op_cnt_q + 32'h0000_0001;
         end
         case (state_q)
            flash_status_pkg::st_read: begin
               if (wr_pulse_q) begin
                  op_bank_q <= wr_bank;
                  op_sector_q <= wr_sector;
                  op_cnt_q <= 32'h0000_0000;
                  if (cmd == `CMD_BUF_LOAD) begin
                     buf_armed_q <= 1'b1;
                  end else if (buf_armed_q && cmd == `CMD_BUF_CONFIRM) begin
                     buf_armed_q <= 1'b0;
                     kind_q <= flash_status_pkg::op_buffer;
                     state_q <= flash_status_pkg::st_program;
                  end else if (buf_armed_q) begin
                     last_bit7_q <= cmd[`POLL_BIT];
                  end else if (cmd == `CMD_ERASE_SECTOR) begin
                     kind_q <= flash_status_pkg::op_sector;
                     state_q <= flash_status_pkg::st_erase;
                  end else if (cmd == `CMD_ERASE_CHIP) begin
                     kind_q <= flash_status_pkg::op_chip;
                     state_q <= flash_status_pkg::st_erase;
                  end else if (cmd == `CMD_PROGRAM) begin
                     kind_q <= flash_status_pkg::op_word; // The data word follows.
                  end else if (cmd != `CMD_RESET) begin
                     kind_q <= flash_status_pkg::op_word;
                     last_bit7_q <= cmd[`POLL_BIT];
                     state_q <= flash_status_pkg::st_program;
                  end
               end
            end
            flash_status_pkg::st_program, flash_status_pkg::st_erase: begin
               if (kind_q == flash_status_pkg::op_buffer && force_abort) begin
                  abort_q <= 1'b1;
                  state_q <= flash_status_pkg::st_fail;
               end else if (op_cnt_q >= 32'(LIMIT_CYCLES)) begin
                  timeout_q <= 1'b1;
                  state_q <= flash_status_pkg::st_fail;
               end else if (!force_stall && op_cnt_q >= 32'(OP_CYCLES)) begin
                  state_q <= flash_status_pkg::st_read;
               end else if (wr_pulse_q && cmd == `CMD_SUSPEND) begin
                  state_q <= (state_q == flash_status_pkg::st_erase) ?
                     flash_status_pkg::st_erase_susp : flash_status_pkg::st_prog_susp;
               end
            end
            flash_status_pkg::st_erase_susp: begin
               if (wr_pulse_q && cmd == `CMD_RESUME) begin
                  state_q <= flash_status_pkg::st_erase;
               end
            end
            flash_status_pkg::st_prog_susp: begin
               if (wr_pulse_q && cmd == `CMD_RESUME) begin
                  state_q <= flash_status_pkg::st_program;
               end
            end
            flash_status_pkg::st_fail: begin
               // Abort needs its own reset sequence; timeout takes the plain one.
               if (wr_pulse_q && cmd == `CMD_ABORT_RESET && buf_armed_q && abort_q) begin
                  abort_q <= 1'b0;
                  buf_armed_q <= 1'b0;
                  state_q <= flash_status_pkg::st_read;
               end else if (wr_pulse_q && cmd == `CMD_BUF_LOAD) begin
                  buf_armed_q <= 1'b1;
               end else if (wr_pulse_q && cmd == `CMD_RESET && !abort_q) begin
                  timeout_q <= 1'b0;
                  state_q <= flash_status_pkg::st_read;
               end
            end
            default: state_q <= flash_status_pkg::st_read;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Read data path and status toggles
   // ------------------------------------------------------------------
   logic toggle_q, sec_toggle_q, in_bank, in_sector, busy_st;
   logic [15:0] status;
   assign busy_st = state_q != flash_status_pkg::st_read;
   assign in_bank = (kind_q == flash_status_pkg::op_chip) || rd_bank == op_bank_q;
   assign in_sector = (kind_q == flash_status_pkg::op_chip) || rd_sector == op_sector_q;

   // Each new read access flips bit 6 during program, erase or failure, and bit 2 in the erasing or erase-suspended sector.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         toggle_q <= 1'b0;
         sec_toggle_q <= 1'b0;
      end else if (rd_fall) begin
         if (state_q == flash_status_pkg::st_program ||
             state_q == flash_status_pkg::st_erase ||
             state_q == flash_status_pkg::st_fail) begin
            toggle_q <= ~toggle_q;
         end
         if (in_sector && (state_q == flash_status_pkg::st_erase ||
                           state_q == flash_status_pkg::st_erase_susp)) begin
            sec_toggle_q <= ~sec_toggle_q;
         end
      end
   end

   always_comb begin
      status = 16'h0000;
      status[`TOGGLE_BIT] = toggle_q;
      status[`SECTOR_TOGGLE_BIT] = sec_toggle_q;
      status[`TIMEOUT_BIT] = timeout_q;
      status[`ABORT_BIT] = abort_q;
      case (state_q)
         flash_status_pkg::st_erase: status[`POLL_BIT] = 1'b0;
         flash_status_pkg::st_erase_susp: status[`POLL_BIT] = 1'b1;
         default: status[`POLL_BIT] = ~last_bit7_q;
      endcase
   end

   logic [15:0] dout_q;
   logic doe_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         dout_q <= 16'h0000;
         doe_q <= 1'b0;
      end else begin
         doe_q <= ~cs_n & ~oe_n & we_n;
         if (state_q == flash_status_pkg::st_prog_susp) begin
            dout_q <= in_sector ? 16'hFFFF : array_data;
         end else if (state_q == flash_status_pkg::st_erase_susp) begin
            dout_q <= in_sector ? status : array_data;
         end else if (busy_st && in_bank) begin
            dout_q <= status;
         end else begin
            dout_q <= array_data;
         end
      end
   end
   assign data_out = dout_q;
   assign data_oe = doe_q;

   // ------------------------------------------------------------------
   // Ready handshake
   // ------------------------------------------------------------------
   logic [2:0] wait_cnt_q;
   logic rdy_q, rdy_oe_q, busy_q, in_burst_q;
   logic [2:0] lead;
   assign lead = ready_early ? 3'h1 : 3'h0;

   // Count burst clocks after the address; ready marks the first word.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         wait_cnt_q <= 3'h0;
         in_burst_q <= 1'b0;
         rdy_q <= 1'b0;
         rdy_oe_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         busy_q <= busy_st;
         rdy_oe_q <= ~cs_n;
         if (!sync_mode || cs_n) begin
            in_burst_q <= 1'b0;
            rdy_q <= ~ready_rising;
         end else if (!av_n && bclk_rise) begin
            in_burst_q <= 1'b1;
            wait_cnt_q <= wait_state_field;
            rdy_q <= ready_rising ? 1'b0 : 1'b1;
         end else if (in_burst_q && bclk_rise && !oe_n) begin
            if (wait_cnt_q > lead) begin
               wait_cnt_q <= wait_cnt_q - 3'h1;
            end else begin
               rdy_q <= ready_rising;
            end
         end
      end
   end
   assign ready = rdy_q;
   assign ready_oe = rdy_oe_q;
   assign busy = busy_q;
endmodule

// ---- testbench/flash_port_asserts.sv ----
`include "flash_status_map.svh"
module flash_port_asserts #(
   parameter int ADDR_W = 22,
   parameter int LIMIT_CYCLES = 100
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic nrst,
   // Host strobes and buses.
   input wire logic chip_select_n,
   input wire logic write_n,
   input wire logic output_n,
   input wire logic sync_mode,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [15:0] data_in,
   // Device outputs.
   input wire logic [15:0] data_out,
   input wire logic data_oe,
   input wire logic ready_oe,
   input wire logic busy,
   input wire logic write_strobe,
   input wire logic [ADDR_W-1:0] write_addr,
   input wire logic [15:0] write_data
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   logic [31:0] busy_cnt_q;

   // Length of the current busy spell; the flag may only rise at its limit.
   always_ff @(posedge clock) begin
      if (!nrst || !busy) begin
         busy_cnt_q <= '0;
      end else begin
         busy_cnt_q <= busy_cnt_q + 1;
      end
   end

   // ---------
   // Properties
   // ---------
   property p_ready_on;
      (!chip_select_n)[*5] |-> ready_oe;
   endproperty
   a_ready_on: assert property (p_ready_on) else $error("ready pin not enabled");
   property p_sel_off;
      chip_select_n[*5] |-> !ready_oe && !data_oe;
   endproperty
   a_sel_off: assert property (p_sel_off) else $error("pins driven unselected");
   property p_read_oe;
      (!chip_select_n && write_n && !output_n && !data_oe)[*5] |-> 1'b0;
   endproperty
   a_read_oe: assert property (p_read_oe) else $error("read bus not driven");
   property p_strobe;
      (!write_n && !chip_select_n)[*3] ##1 write_n |-> ##[1:4] write_strobe;
   endproperty
   a_strobe: assert property (p_strobe) else $error("write not taken");
   property p_wdata;
      write_strobe |-> write_data == $past(data_in);
   endproperty
   a_wdata: assert property (p_wdata) else $error("wrong write data");
   property p_waddr;
      write_strobe && !sync_mode |-> write_addr == $past(addr);
   endproperty
   a_waddr: assert property (p_waddr) else $error("wrong write address");
   property p_hold;
      !write_strobe |-> $stable(write_addr) && $stable(write_data);
   endproperty
   a_hold: assert property (p_hold) else $error("write capture moved");
   property p_timeout;
      data_oe && busy_cnt_q + 4 < LIMIT_CYCLES |-> !data_out[`TIMEOUT_BIT];
   endproperty
   a_timeout: assert property (p_timeout) else $error("early timeout flag");
   property p_abort;
      data_oe && data_out[`ABORT_BIT] |-> busy;
   endproperty
   a_abort: assert property (p_abort) else $error("abort flag while idle");
   c_write: cover property (write_strobe && sync_mode);
   c_timeout: cover property (data_oe && data_out[`TIMEOUT_BIT]);
   c_abort: cover property (data_oe && data_out[`ABORT_BIT]);
endmodule

bind flash_write_status_and_command_port flash_port_asserts #(
   .ADDR_W(ADDR_W),
   .LIMIT_CYCLES(LIMIT_CYCLES)
) flash_port_asserts_i (
   .clock(clock),
   .nrst(nrst),
   .chip_select_n(chip_select_n),
   .write_n(write_n),
   .output_n(output_n),
   .sync_mode(sync_mode),
   .addr(addr),
   .data_in(data_in),
   .data_out(data_out),
   .data_oe(data_oe),
   .ready_oe(ready_oe),
   .busy(busy),
   .write_strobe(write_strobe),
   .write_addr(write_addr),
   .write_data(write_data)
);

// ---- testbench/flash_host_model.sv ----
module flash_host_model #(
   parameter int ADDR_W = 22
) (
   // Clock.
   input wire logic clock,
   // Strobes towards the device.
   output logic chip_select_n,
   output logic write_n,
   output logic output_n,
   output logic address_valid_n,
   output logic burst_clk,
   // Buses.
   output logic [ADDR_W-1:0] addr,
   output logic [15:0] data_in,
   input wire logic [15:0] data_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus: nothing selected, link clock still.
   initial begin
      chip_select_n = 1'b1;
      write_n = 1'b1;
      output_n = 1'b1;
      address_valid_n = 1'b1;
      burst_clk = 1'b0;
      addr = '0;
      data_in = 16'h0000;
   end

   // One write; the clocked variant moves the address after latching it.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic sync);
      @(posedge clock);
      chip_select_n <= 1'b0;
      addr <= a;
      if (sync) begin
         address_valid_n <= 1'b0;
         repeat (4) @(posedge clock);
         burst_clk <= 1'b1;
         repeat (4) @(posedge clock);
         burst_clk <= 1'b0;
         address_valid_n <= 1'b1;
         addr <= ~a;
         repeat (4) @(posedge clock);
      end
      write_n <= 1'b0;
      data_in <= d;
      repeat (4) @(posedge clock);
      write_n <= 1'b1;
      chip_select_n <= 1'b1;
      repeat (5) @(posedge clock);
      data_in <= ~d;
      addr <= ~addr;
   endtask

   // One read; the address is driven on the same clock edge as select falls.
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] q);
      @(posedge clock);
      chip_select_n <= 1'b0;
      output_n <= 1'b0;
      addr <= a;
      repeat (6) @(posedge clock);
      q = data_out;
      chip_select_n <= 1'b1;
      output_n <= 1'b1;
      repeat (3) @(posedge clock);
   endtask

   // Burst opening: a clocked address, then n link clocks with the output strobe low.
   // Select stays low on return so that ready can be judged; the next call releases it.
   task automatic burst(input logic [ADDR_W-1:0] a, input int n);
      @(posedge clock);
      chip_select_n <= 1'b1;
      output_n <= 1'b1;
      repeat (4) @(posedge clock);
      chip_select_n <= 1'b0;
      address_valid_n <= 1'b0;
      addr <= a;
      for (int i = 0; i <= n; i++) begin
         repeat (4) @(posedge clock);
         burst_clk <= 1'b1;
         repeat (4) @(posedge clock);
         burst_clk <= 1'b0;
         address_valid_n <= 1'b1;
         output_n <= 1'b0;
      end
      repeat (4) @(posedge clock);
   endtask
endmodule

// ---- testbench/test_flash_write_status_and_command_port.sv ----
`include "flash_status_map.svh"
module test_flash_write_status_and_command_port;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int AW = 22;
   localparam int LIM = 2000;
   localparam logic [AW-1:0] A0 = 22'h10_2000;
   localparam logic [AW-1:0] A1 = 22'h11_2000;
   localparam logic [AW-1:0] A2 = 22'h30_0000;
   localparam logic [AW-1:0] A3 = 22'h20_0040;
   localparam logic [AW-1:0] A3N = ~A3;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic sync_mode, ready_rising, ready_early, force_abort, force_stall;
   logic chip_select_n, write_n, output_n, address_valid_n, burst_clk;
   logic data_oe, ready, ready_oe, busy, write_strobe;
   logic [2:0] wait_state_field;
   logic [AW-1:0] addr, write_addr;
   logic [15:0] data_in, data_out, array_data, write_data, s1, s2, q;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;

   always #25 clock = ~clock;

   flash_write_status_and_command_port #(
      .OP_CYCLES(200),
      .LIMIT_CYCLES(LIM)
   ) flash_write_status_and_command_port_i (
      .clock(clock), .nrst(nrst), .chip_select_n(chip_select_n), .write_n(write_n),
      .output_n(output_n), .address_valid_n(address_valid_n), .burst_clk(burst_clk),
      .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .sync_mode(sync_mode), .ready_rising(ready_rising), .ready_early(ready_early),
      .wait_state_field(wait_state_field), .array_data(array_data),
      .force_abort(force_abort), .force_stall(force_stall), .ready(ready),
      .ready_oe(ready_oe), .busy(busy), .write_strobe(write_strobe),
      .write_addr(write_addr), .write_data(write_data)
   );

   flash_host_model #(
      .ADDR_W(AW)
   ) flash_host_model_i (
      .clock(clock), .chip_select_n(chip_select_n), .write_n(write_n),
      .output_n(output_n), .address_valid_n(address_valid_n), .burst_clk(burst_clk),
      .addr(addr), .data_in(data_in), .data_out(data_out)
   );

   // Array contents; the timeout and abort bit places are kept clear so those flags never alias data.
   function automatic logic [15:0] arr(input logic [AW-1:0] a);
      return (a[15:0] ^ 16'h3C00) & 16'hFFDD;
   endfunction

   // Array model and hang guard.
   always @(posedge clock) begin
      array_data <= arr(addr);
      cyc = cyc + 1;
      if (cyc == 20000) begin
         error_cnt += 1;
         results();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done += 1;
      if (seen !== exp) begin
         error_cnt += 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [15:0] d, input logic s);
      flash_host_model_i.wr(a, d, s);
   endtask

   task automatic rd(input logic [AW-1:0] a, output logic [15:0] v);
      flash_host_model_i.rd(a, v);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clock);
      chk(busy, 1'b0);
   endtask

   task automatic t_program();
      wr(A0, `CMD_PROGRAM, 1'b0);
      chk(write_addr, A0);
      chk(write_data, `CMD_PROGRAM);
      wr(A0, 16'h0011, 1'b0);
      rd(A0, s1);
      rd(A0, s2);
      chk(s1[7], 1'b1);
      chk(s1[6] ^ s2[6], 1'b1);
      chk(s1[5], 1'b0);
      chk(s1[1], 1'b0);
      rd(A2, q);
      chk(q, arr(A2));
      wr(A0, `CMD_SUSPEND, 1'b0);
      rd(A1, q);
      chk(q, arr(A1));
      wr(A0, `CMD_RESUME, 1'b0);
      wait_idle();
      rd(A0, s1);
      rd(A0, s2);
      chk(s1, arr(A0));
      chk(s2, arr(A0));
   endtask

   // Buffered load, the last word deciding the polled value; optional abort.
   task automatic t_buffer(input logic ab);
      wr(A0, `CMD_BUF_LOAD, 1'b0);
      wr(A0, 16'h0080, 1'b0);
      wr(A0 + 1, 16'h0011, 1'b0);
      wr(A0, `CMD_BUF_CONFIRM, 1'b0);
      force_abort <= ab;
      rd(A0, s1);
      chk(s1[7], 1'b1);
      chk(s1[1], ab);
      if (ab) begin
         wr(A0, `CMD_RESET, 1'b0);
         force_abort <= 1'b0;
         rd(A0, s1);
         chk(s1[1], 1'b1);
         wr(A0, `CMD_BUF_LOAD, 1'b0);
         wr(A0, `CMD_ABORT_RESET, 1'b0);
      end
      wait_idle();
      rd(A0, q);
      chk(q, arr(A0));
   endtask

   task automatic t_timeout();
      force_stall <= 1'b1;
      wr(A0, `CMD_PROGRAM, 1'b0);
      wr(A0, 16'h0080, 1'b0);
      repeat (LIM) @(posedge clock);
      rd(A0, s1);
      chk(s1[5], 1'b1);
      force_stall <= 1'b0;
      wr(A0, `CMD_RESET, 1'b0);
      wait_idle();
      rd(A0, q);
      chk(q, arr(A0));
   endtask

   task automatic t_erase();
      wr(A0, `CMD_ERASE_SECTOR, 1'b0);
      rd(A0, s1);
      rd(A0, s2);
      chk(s1[7], 1'b0);
      chk(s1[2] ^ s2[2], 1'b1);
      wr(A0, `CMD_SUSPEND, 1'b0);
      rd(A0, s1);
      rd(A0, s2);
      chk(s1[7], 1'b1);
      chk(s1[6] ^ s2[6], 1'b0);
      chk(s1[2] ^ s2[2], 1'b1);
      rd(A1, q);
      chk(q, arr(A1));
      wr(A0, `CMD_RESUME, 1'b0);
      wait_idle();
      wr(A0, `CMD_ERASE_CHIP, 1'b0);
      rd(A2, s1);
      chk(s1[7], 1'b0);
      wait_idle();
   endtask

   // Clocked address latch honoured only in synchronous mode.
   task automatic t_sync();
      sync_mode <= 1'b1;
      wr(A3, `CMD_RESET, 1'b1);
      chk(write_addr, A3);
      chk(write_data, `CMD_RESET);
      wr(A2, `CMD_RESET, 1'b0);
      chk(write_addr, A2);
      sync_mode <= 1'b0;
      wr(A3, `CMD_RESET, 1'b1);
      chk(write_addr, A3N);
   endtask

   // Ready marks the first burst word after two wait states, a clock early on request.
   task automatic t_ready(input logic early, input logic rise);
      sync_mode <= 1'b1;
      ready_early <= early;
      ready_rising <= rise;
      flash_host_model_i.burst(A2, 2);
      chk(ready, rise ^ !early);
      chk(ready_oe, 1'b1);
      flash_host_model_i.burst(A2, 3);
      chk(ready, rise);
   endtask

   task automatic results();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Reset, then every scenario in turn.
   initial begin
      sync_mode = 1'b0;
      ready_rising = 1'b0;
      ready_early = 1'b0;
      wait_state_field = 3'h2;
      force_abort = 1'b0;
      force_stall = 1'b0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      t_program();
      t_buffer(1'b0);
      t_buffer(1'b1);
      t_timeout();
      t_erase();
      t_sync();
      t_ready(1'b0, 1'b0);
      t_ready(1'b1, 1'b1);
      results();
   end
endmodule
